// ### pkg/apc_pkg.sv
// Constants and carrier types for the audio port control register bank.
package apc_pkg;
  // Register offsets.
  localparam logic [7:0] APC_OFS_WRAP = 8'h06;
  localparam logic [7:0] APC_OFS_DEEMPH_ENABLE = 8'h07;
  localparam logic [7:0] APC_OFS_PIN = 8'h08;
  localparam logic [7:0] APC_OFS_CLK = 8'h09;
  // Field positions.
  localparam int APC_BIT_WRAP_DIS = 3;
  localparam int APC_BIT_DEEMPH = 4;
  localparam int APC_BIT_SRC_SEL = 0;
  localparam int APC_BIT_SD_DRV = 5;
  localparam int APC_BIT_MUTE_FWD = 4;
  localparam int APC_BIT_BCK_INV = 5;
  localparam int APC_BIT_BCK_DRV = 4;
  localparam int APC_BIT_FRM_DRV = 0;
  // Reset values of the writable fields.
  localparam logic APC_RST_WRAP_DIS = 1'h0;
  localparam logic APC_RST_DEEMPH = 1'h0;
  localparam logic APC_RST_SRC_SEL = 1'h1;
  localparam logic APC_RST_SD_DRV = 1'h0;
  localparam logic APC_RST_MUTE_FWD = 1'h0;
  localparam logic APC_RST_BCK_INV = 1'h0;
  localparam logic APC_RST_BCK_DRV = 1'h0;
  localparam logic APC_RST_FRM_DRV = 1'h0;
  // Auto-increment addressing within a page.
  localparam logic [6:0] APC_PAGE_LAST = 7'h7F;
  localparam logic [6:0] APC_PAGE_RESUME = 7'h08;
  localparam logic [6:0] APC_PAGE_FIRST = 7'h00;
  localparam logic [7:0] APC_BOOK_ZERO = 8'h00;
  // De-emphasis coefficients, Q2.14, defaults tuned for 44.1 kHz.
  localparam int APC_COEF_FRAC = 14;
  localparam logic [15:0] APC_COEF_B0_RST = 16'h2A3D;
  localparam logic [15:0] APC_COEF_B1_RST = 16'hF0A4;
  localparam logic [15:0] APC_COEF_A1_RST = 16'h0A7F;
  localparam logic [1:0] APC_COEF_B0 = 2'h0;
  localparam logic [1:0] APC_COEF_B1 = 2'h1;
  localparam logic [1:0] APC_COEF_A1 = 2'h2;

  // Control fields decoded from the four registers.
  typedef struct packed {
    logic wrap_dis;
    logic deemph_enable;
    logic src_sel;
    logic sd_drive;
    logic mute_fwd;
    logic bck_invert;
    logic bck_drive;
    logic frm_drive;
  } apc_ctl_t;

  // One captured serial sample point.
  typedef struct packed {
    logic frm;
    logic din;
  } apc_smp_t;
endpackage

// ### rtl/apc_clkdiv.sv
// Programmable clock divider producing a level and its edge pulses.
`timescale 1ns/1ps
module apc_clkdiv
  import apc_pkg::*;
(
  input wire logic clk, // Block clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic run, // Divider runs when high, held in reset when low.
  input wire logic step, // Advance enable, one pulse per input period.
  input wire logic [7:0] half, // Steps per half period, zero acts as one.
  output logic level_r, // Divided clock level.
  output logic rise, // Pulse where level goes high.
  output logic fall // Pulse where level goes low.
);
  logic [7:0] cnt_r;
  logic wrap;

  // A zero factor would never wrap, so it is treated as a factor of one.
  // A stopped divider must not pulse, or a master sampler would fire.
  assign wrap = run && step && ((half == 8'h00) || (cnt_r + 8'h01 >= half));
  assign rise = wrap && !level_r;
  assign fall = wrap && level_r;

  // Counter and level; a stopped divider parks low.
  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      cnt_r <= 8'h00;
      level_r <= 1'b0;
    end
    else if (wrap)
    begin
      cnt_r <= 8'h00;
      level_r <= !level_r;
    end
    else if (step)
    begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

// ### rtl/apc_regs.sv
// Audio port control registers with the serial port logic they steer.
//
// Summary of operation
// - Wrap enabled: next page, address eight; book zero goes back to address zero.
// - Wrap disabled: back to address zero.
// - De-emphasis bit inserts filter; reset off.
// - Filter defaults 44.1 kHz; rewritable coefficients.
// - Source select: processed or raw output.
// - Serial output drive enable; reset input.
// - Mute forwarding gate to power stage.
// - Bit clock invert picks sampling edge.
// - Bit clock drive enable selects master.
// - Master bit clock divides master clock.
// - Frame clock drive enable selects master.
// - Master frame clock divides master bit clock.
`timescale 1ns/1ps
module apc_regs
  import apc_pkg::*;
(
  input wire logic REF_CLK, // 250 MHz master clock.
  input wire logic RST_N, // Synchronous reset, active low.
  input wire logic REG_WR, // Register write strobe.
  input wire logic REG_RD, // Register read strobe.
  input wire logic [7:0] REG_ADDR, // Register offset.
  input wire logic [7:0] REG_WDATA, // Write data.
  output logic [7:0] REG_RDATA, // Read data, registered.
  output logic REG_RVALID, // Read data valid pulse.
  input wire logic AI_STEP, // Advance the auto-increment pointer.
  input wire logic [7:0] AI_BOOK, // Current book.
  input wire logic [7:0] AI_PAGE, // Current page.
  input wire logic [6:0] AI_ADDR, // Current address in page.
  output logic [7:0] AI_NXT_PAGE, // Page of next access.
  output logic [6:0] AI_NXT_ADDR, // Address of next access.
  input wire logic COEF_WR, // Coefficient memory write strobe.
  input wire logic [1:0] COEF_IDX, // Coefficient index.
  input wire logic [15:0] COEF_WDATA, // Coefficient value.
  input wire logic AUD_VLD, // Audio sample strobe.
  input wire logic [15:0] AUD_IN, // Audio sample in.
  output logic [15:0] AUD_OUT, // Audio sample out, registered.
  output logic AUD_OUT_VLD, // Audio out strobe.
  output logic DEEMPH_ON, // De-emphasis in path.
  input wire logic DSP_POST_SD, // Processed serial data bit.
  input wire logic DSP_PRE_SD, // Unprocessed serial data bit.
  input wire logic SERIAL_DATA_OUT_I, // Serial output pin, input side.
  output logic SERIAL_DATA_OUT_O, // Serial output pin data.
  output logic SERIAL_DATA_OUT_OE_N, // Serial output pin enable, active low.
  input wire logic MUTE_REQ, // Mute request from converter core.
  output logic PA_MUTE, // Mute to power stage.
  input wire logic BCK_DIV_RUN, // Bit clock divider running.
  input wire logic [7:0] BCK_HALF, // Master clocks per bit clock half.
  input wire logic FRM_DIV_RUN, // Frame clock divider running.
  input wire logic [7:0] FRM_HALF, // Bit clocks per frame half.
  input wire logic BCK_I, // Bit clock pin, input side.
  output logic BCK_O, // Bit clock pin drive.
  output logic BCK_OE_N, // Bit clock pin enable, active low.
  input wire logic FRM_I, // Frame clock pin, input side.
  output logic FRM_O, // Frame clock pin drive.
  output logic FRM_OE_N, // Frame clock pin enable, active low.
  input wire logic DIN, // Serial input data.
  output logic SMP_STB, // Sample taken pulse.
  output logic SMP_FRM, // Sampled frame clock.
  output logic SMP_DIN // Sampled serial data.
);
  apc_ctl_t ctl_r;
  apc_smp_t smp_r;
  logic [7:0] rdata_nxt;
  logic [15:0] coef_r [0:2];
  logic signed [15:0] x1_r;
  logic signed [15:0] y1_r;
  logic signed [33:0] acc;
  logic signed [15:0] y_nxt;
  logic bck_lvl, bck_rise, bck_fall;
  logic frm_lvl;
  logic bck_in_r;
  logic edge_rise, edge_fall, smp_edge;

  // Register writes; only documented fields are stored.
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      ctl_r.wrap_dis <= APC_RST_WRAP_DIS;
      ctl_r.deemph_enable <= APC_RST_DEEMPH;
      ctl_r.src_sel <= APC_RST_SRC_SEL;
      ctl_r.sd_drive <= APC_RST_SD_DRV;
      ctl_r.mute_fwd <= APC_RST_MUTE_FWD;
      ctl_r.bck_invert <= APC_RST_BCK_INV;
      ctl_r.bck_drive <= APC_RST_BCK_DRV;
      ctl_r.frm_drive <= APC_RST_FRM_DRV;
    end
    else if (REG_WR)
    begin
      // Reserved bits are dropped here, so writing them changes nothing.
      case (REG_ADDR)
        APC_OFS_WRAP:
        begin
          ctl_r.wrap_dis <= REG_WDATA[APC_BIT_WRAP_DIS];
        end
        APC_OFS_DEEMPH_ENABLE:
        begin
          ctl_r.deemph_enable <= REG_WDATA[APC_BIT_DEEMPH];
          ctl_r.src_sel <= REG_WDATA[APC_BIT_SRC_SEL];
        end
        APC_OFS_PIN:
        begin
          ctl_r.sd_drive <= REG_WDATA[APC_BIT_SD_DRV];
          ctl_r.mute_fwd <= REG_WDATA[APC_BIT_MUTE_FWD];
        end
        APC_OFS_CLK:
        begin
          ctl_r.bck_invert <= REG_WDATA[APC_BIT_BCK_INV];
          ctl_r.bck_drive <= REG_WDATA[APC_BIT_BCK_DRV];
          ctl_r.frm_drive <= REG_WDATA[APC_BIT_FRM_DRV];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Read mux; reserved bits and unmapped offsets read as zero.
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (REG_ADDR)
      APC_OFS_WRAP: rdata_nxt[APC_BIT_WRAP_DIS] = ctl_r.wrap_dis;
      APC_OFS_DEEMPH_ENABLE:
      begin
        rdata_nxt[APC_BIT_DEEMPH] = ctl_r.deemph_enable;
        rdata_nxt[APC_BIT_SRC_SEL] = ctl_r.src_sel;
      end
      APC_OFS_PIN:
      begin
        rdata_nxt[APC_BIT_SD_DRV] = ctl_r.sd_drive;
        rdata_nxt[APC_BIT_MUTE_FWD] = ctl_r.mute_fwd;
      end
      APC_OFS_CLK:
      begin
        rdata_nxt[APC_BIT_BCK_INV] = ctl_r.bck_invert;
        rdata_nxt[APC_BIT_BCK_DRV] = ctl_r.bck_drive;
        rdata_nxt[APC_BIT_FRM_DRV] = ctl_r.frm_drive;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data register, answered one cycle after the strobe.
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
      begin
        REG_RDATA <= rdata_nxt;
      end
    end
  end

  // Auto-increment pointer; book zero always wraps inside its page.
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      AI_NXT_PAGE <= 8'h00;
      AI_NXT_ADDR <= 7'h00;
    end
    else if (AI_STEP)
    begin
      if (AI_ADDR != APC_PAGE_LAST)
      begin
        AI_NXT_PAGE <= AI_PAGE;
        AI_NXT_ADDR <= AI_ADDR + 7'h01;
      end
      else if (!ctl_r.wrap_dis && AI_BOOK != APC_BOOK_ZERO)
      begin
        AI_NXT_PAGE <= AI_PAGE + 8'h01;
        AI_NXT_ADDR <= APC_PAGE_RESUME;
      end
      else
      begin
        AI_NXT_PAGE <= AI_PAGE;
        AI_NXT_ADDR <= APC_PAGE_FIRST;
      end
    end
  end

  // Coefficient memory; a write takes effect on the next sample.
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      coef_r[APC_COEF_B0] <= APC_COEF_B0_RST;
      coef_r[APC_COEF_B1] <= APC_COEF_B1_RST;
      coef_r[APC_COEF_A1] <= APC_COEF_A1_RST;
    end
    else if (COEF_WR && COEF_IDX <= APC_COEF_A1)
    begin
      coef_r[COEF_IDX] <= COEF_WDATA;
    end
  end

  // First-order shelving section; state keeps running while bypassed so
  // that enabling it mid-stream does not start from a stale history.
  always_comb
  begin
    acc = $signed(coef_r[APC_COEF_B0]) * $signed(AUD_IN)
        + $signed(coef_r[APC_COEF_B1]) * x1_r
        + $signed(coef_r[APC_COEF_A1]) * y1_r;
    y_nxt = acc[APC_COEF_FRAC +: 16];
  end

  // Filter history and output selection.
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      x1_r <= 16'sh0000;
      y1_r <= 16'sh0000;
      AUD_OUT <= 16'h0000;
      AUD_OUT_VLD <= 1'b0;
    end
    else
    begin
      AUD_OUT_VLD <= AUD_VLD;
      if (AUD_VLD)
      begin
        x1_r <= $signed(AUD_IN);
        y1_r <= y_nxt;
        AUD_OUT <= ctl_r.deemph_enable ? y_nxt : AUD_IN;
      end
    end
  end

  assign DEEMPH_ON = ctl_r.deemph_enable;

  // Serial output source and mute forwarding.
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      SERIAL_DATA_OUT_O <= 1'b0;
      PA_MUTE <= 1'b0;
    end
    else
    begin
      SERIAL_DATA_OUT_O <= ctl_r.src_sel ? DSP_PRE_SD : DSP_POST_SD;
      PA_MUTE <= MUTE_REQ && ctl_r.mute_fwd;
    end
  end

  // The pin only turns round when software asks; input side unused here.
  assign SERIAL_DATA_OUT_OE_N = !ctl_r.sd_drive;

  // Bit clock from the master clock.
  apc_clkdiv u_bck_div (
    .clk (REF_CLK),
    .rst_n (RST_N),
    .run (BCK_DIV_RUN && ctl_r.bck_drive),
    .step (1'b1),
    .half (BCK_HALF),
    .level_r (bck_lvl),
    .rise (bck_rise),
    .fall (bck_fall)
  );

  // Frame clock counts master bit clock falling edges.
  apc_clkdiv u_frm_div (
    .clk (REF_CLK),
    .rst_n (RST_N),
    .run (FRM_DIV_RUN && ctl_r.frm_drive),
    .step (bck_fall),
    .half (FRM_HALF),
    .level_r (frm_lvl),
    .rise (),
    .fall ()
  );

  assign BCK_O = bck_lvl;
  assign BCK_OE_N = !ctl_r.bck_drive;
  assign FRM_O = frm_lvl;
  assign FRM_OE_N = !ctl_r.frm_drive;

  // Pin inputs are synchronous, so one delay stage suffices for edges.
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      bck_in_r <= 1'b0;
    end
    else
    begin
      bck_in_r <= BCK_I;
    end
  end

  // In master mode the divider edges stand in for the pin edges, since
  // the source aligns its data to the clocks this block drives.
  assign edge_rise = ctl_r.bck_drive ? bck_rise : (BCK_I && !bck_in_r);
  assign edge_fall = ctl_r.bck_drive ? bck_fall : (!BCK_I && bck_in_r);
  assign smp_edge = ctl_r.bck_invert ? edge_rise : edge_fall;

  // Sample point capture
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      smp_r <= '0;
      SMP_STB <= 1'b0;
    end
    else
    begin
      SMP_STB <= smp_edge;
      if (smp_edge)
      begin
        smp_r.frm <= ctl_r.frm_drive ? frm_lvl : FRM_I;
        smp_r.din <= DIN;
      end
    end
  end

  assign SMP_FRM = smp_r.frm;
  assign SMP_DIN = smp_r.din;
endmodule

// ### verif/apc_src_model.sv
// Behavioural serial audio source on the far side of the port.
`timescale 1ns/1ps
module apc_src_model (
  input wire logic clk, // Reference clock.
  input wire logic run, // Source active.
  input wire logic dev_mst, // Block drives the bit clock.
  input wire logic dev_bck, // Bit clock from the block.
  input wire logic inv, // Block samples on rising edges.
  output logic bck, // Bit clock in slave operation.
  output logic frm, // Frame clock in slave operation.
  output logic din // Serial data.
);
  logic [1:0] div_r;
  logic [7:0] pat_r = 8'hB5;
  logic [2:0] cnt_r;
  logic bck_q;
  logic bck_l;
  // Data follows whichever party owns the bit clock.
  assign bck_l = dev_mst ? dev_bck : bck;
  assign din = pat_r[0];
  // The clock stands low while idle; data moves on the non-sampling edge.
  always @(posedge clk)
  begin
    bck_q <= bck_l;
    div_r <= (!run || div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
    if (!run)
    begin
      bck <= 1'b0;
      frm <= 1'b0;
      cnt_r <= 3'h0;
    end
    else if (!dev_mst && div_r == 2'h2)
      bck <= !bck;
    if (run && bck_l != bck_q && bck_l == !inv)
    begin
      pat_r <= {pat_r[6:0], pat_r[7] ^ pat_r[5]};
      cnt_r <= cnt_r + 3'h1;
      frm <= (cnt_r == 3'h7) ? !frm : frm;
    end
  end
endmodule

// ### verif/apc_regs_assertions.sv
// Port checker for the audio port control register bank.
`timescale 1ns/1ps
module apc_regs_assertions
  import apc_pkg::*;
(
  input wire logic REF_CLK, // Clock.
  input wire logic RST_N, // Reset, active low.
  input wire logic REG_RD, // Read strobe.
  input wire logic [7:0] REG_ADDR, // Offset.
  input wire logic [7:0] REG_RDATA, // Read data.
  input wire logic REG_RVALID, // Read valid.
  input wire logic AI_STEP, // Pointer advance.
  input wire logic [7:0] AI_PAGE, // Page.
  input wire logic [6:0] AI_ADDR, // Address.
  input wire logic [7:0] AI_NXT_PAGE, // Next page.
  input wire logic [6:0] AI_NXT_ADDR, // Next address.
  input wire logic AUD_VLD, // Sample strobe.
  input wire logic [15:0] AUD_IN, // Sample in.
  input wire logic [15:0] AUD_OUT, // Sample out.
  input wire logic AUD_OUT_VLD, // Sample out strobe.
  input wire logic DEEMPH_ON, // Filter in path.
  input wire logic MUTE_REQ, // Mute request.
  input wire logic PA_MUTE, // Mute to power stage.
  input wire logic BCK_DIV_RUN, // Divider run.
  input wire logic [7:0] BCK_HALF, // Half period.
  input wire logic BCK_I, // Bit clock in.
  input wire logic BCK_O, // Bit clock out.
  input wire logic BCK_OE_N, // Bit clock enable, active low.
  input wire logic DIN, // Serial data.
  input wire logic SMP_STB, // Sample pulse.
  input wire logic SMP_DIN // Sampled data.
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // A half count of two keeps the bit clock high for two cycles exactly.
  sequence s_high_two;
    BCK_O [*2] ##1 !BCK_O;
  endsequence
  a_rd_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read strobe not answered");
  a_unmapped_zero: assert property
    (REG_RD && (REG_ADDR < 8'h06 || REG_ADDR > 8'h09) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_ai_plain_step: assert property
    (AI_STEP && AI_ADDR != 7'h7F |=> AI_NXT_ADDR == $past(AI_ADDR) + 7'h01
    && AI_NXT_PAGE == $past(AI_PAGE)) else $error("address step wrong");
  a_bypass_pass: assert property (AUD_VLD && !DEEMPH_ON |=>
    AUD_OUT_VLD && AUD_OUT == $past(AUD_IN)) else $error("bypass altered");
  a_mute_idle: assert property (!MUTE_REQ |=> !PA_MUTE)
    else $error("mute without request");
  a_bck_idle: assert property
    (BCK_OE_N && $past(BCK_OE_N) |-> !BCK_O)
    else $error("bit clock moves in slave");
  a_bck_period: assert property
    (disable iff (!RST_N || !BCK_DIV_RUN)
    $rose(BCK_O) && BCK_HALF == 8'h02 |-> s_high_two)
    else $error("bit clock half period wrong");
  a_smp_edge: assert property (SMP_STB && $past(BCK_OE_N) |->
    $past(BCK_I) != $past(BCK_I, 2) && SMP_DIN == $past(DIN))
    else $error("sample off an edge");
endmodule
bind apc_regs apc_regs_assertions chk (.*);

// ### verif/apc_regs_tb.sv
// Self-checking bench for the audio port control register bank.
`timescale 1ns/1ps
module apc_regs_tb
  import apc_pkg::*;
;
  logic REF_CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, AI_STEP = 0;
  logic COEF_WR = 0, AUD_VLD = 0, DSP_POST_SD = 0, DSP_PRE_SD = 0;
  logic SERIAL_DATA_OUT_I = 0, MUTE_REQ = 0, BCK_DIV_RUN = 0, FRM_DIV_RUN = 0;
  logic src_run = 0, inv = 0;
  logic [7:0] REG_ADDR = 0, REG_WDATA = 0, AI_BOOK = 0, AI_PAGE = 0;
  logic [7:0] BCK_HALF = 0, FRM_HALF = 0, REG_RDATA, AI_NXT_PAGE;
  logic [6:0] AI_ADDR = 0, AI_NXT_ADDR;
  logic [1:0] COEF_IDX = 0, bck_h;
  logic [15:0] COEF_WDATA = 0, AUD_IN = 0, AUD_OUT;
  logic REG_RVALID, AUD_OUT_VLD, DEEMPH_ON, SERIAL_DATA_OUT_O, SERIAL_DATA_OUT_OE_N, PA_MUTE;
  logic BCK_O, BCK_OE_N, FRM_O, FRM_OE_N, SMP_STB, SMP_FRM, SMP_SD;
  wire BCK_I, FRM_I, DIN, src_bck, src_frm;
  int failures = 0, cmp_count = 0;
  // Each pin carries whichever party has its driver enabled.
  assign BCK_I = BCK_OE_N ? src_bck : BCK_O;
  assign FRM_I = FRM_OE_N ? src_frm : FRM_O;
  apc_regs dut (.*, .SMP_DIN(SMP_SD));
  apc_src_model src (.clk(REF_CLK), .run(src_run), .dev_mst(!BCK_OE_N),
    .dev_bck(BCK_O), .inv(inv), .bck(src_bck), .frm(src_frm), .din(DIN));
  // Clock and bit clock history for edge checks.
  initial forever #2 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) bck_h <= {bck_h[0], BCK_I};
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge REF_CLK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
    @(posedge REF_CLK) REG_WR <= 0;
    // Let the written field settle before any caller looks at the pins.
    @(negedge REF_CLK);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge REF_CLK) {REG_RD, REG_ADDR} <= {1'b1, a};
    @(posedge REF_CLK) REG_RD <= 0;
    @(negedge REF_CLK) chk("rdata", {8'h00, e}, {8'h00, REG_RDATA});
    chk("rvalid", 16'h1, {15'h0, REG_RVALID});
  endtask
  task automatic ai(logic [7:0] b, logic [6:0] a, logic [7:0] p,
    logic [6:0] q);
    @(posedge REF_CLK)
      {AI_STEP, AI_BOOK, AI_PAGE, AI_ADDR} <= {1'b1, b, 8'h02, a};
    @(posedge REF_CLK) AI_STEP <= 0;
    @(negedge REF_CLK)
      chk("next", {p, 1'b0, q}, {AI_NXT_PAGE, 1'b0, AI_NXT_ADDR});
  endtask
  task automatic aud(logic [15:0] x, logic [15:0] e);
    @(posedge REF_CLK) {AUD_VLD, AUD_IN} <= {1'b1, x};
    @(posedge REF_CLK) AUD_VLD <= 0;
    @(negedge REF_CLK) chk("audio", e, AUD_OUT);
    chk("audvld", 16'h1, {15'h0, AUD_OUT_VLD});
  endtask
  task automatic coef(logic [1:0] i, logic [15:0] v);
    @(posedge REF_CLK) {COEF_WR, COEF_IDX, COEF_WDATA} <= {1'b1, i, v};
    @(posedge REF_CLK) COEF_WR <= 0;
  endtask
  task automatic pin(string n, logic e);
    repeat (2) @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk(n, {15'h0, e}, {15'h0, n == "mute" ? PA_MUTE : SERIAL_DATA_OUT_O});
  endtask
  task automatic per(bit f, int e);
    int n = 0;
    logic p = 1;
    for (int r = 0; r < 2 && n < 200;)
    begin
      @(negedge REF_CLK);
      n += (r > 0);
      r += ((f ? FRM_O : BCK_O) && !p);
      p = f ? FRM_O : BCK_O;
    end
    chk("period", 16'(e), 16'(n));
  endtask
  // Registers after reset, then all ones to expose reserved bits.
  task automatic t_regs;
    logic [7:0] m[4] = '{8'h08, 8'h11, 8'h30, 8'h31};
    chk("sdoe", 16'h1, {15'h0, SERIAL_DATA_OUT_OE_N});
    chk("bckoe", 16'h1, {15'h0, BCK_OE_N});
    chk("frmoe", 16'h1, {15'h0, FRM_OE_N});
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h01);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h06 + 8'(i), 8'hFF);
      rd(8'h06 + 8'(i), m[i]);
      wr(8'h06 + 8'(i), 8'h00);
    end
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    rd(8'h0A, 8'h00);
  endtask
  // Auto-increment across page ends, both wrap modes and book zero.
  task automatic t_wrap;
    ai(8'h01, 7'h7F, 8'h03, 7'h08);
    ai(8'h01, 7'h10, 8'h02, 7'h11);
    ai(8'h00, 7'h7F, 8'h02, 7'h00);
    wr(8'h06, 8'h08);
    ai(8'h01, 7'h7F, 8'h02, 7'h00);
  endtask
  // With the feedback term cleared, an impulse shows both feedforward coefficients.
  task automatic t_filter;
    wr(8'h07, 8'h11);
    chk("deemph", 16'h1, {15'h0, DEEMPH_ON});
    coef(2'h2, 16'h0000);
    aud(16'h0000, 16'h0000);
    aud(16'h4000, APC_COEF_B0_RST);
    aud(16'h0000, APC_COEF_B1_RST);
    coef(2'h0, 16'h1000);
    aud(16'h4000, 16'h1000);
    wr(8'h07, 8'h01);
    aud(16'h1234, 16'h1234);
  endtask
  // Output pin source, direction and mute forwarding.
  task automatic t_pins;
    {DSP_POST_SD, DSP_PRE_SD, MUTE_REQ} <= 3'b101;
    wr(8'h08, 8'h30);
    wr(8'h07, 8'h00);
    pin("serial_data_out", 1'b1);
    chk("sdoe", 16'h0, {15'h0, SERIAL_DATA_OUT_OE_N});
    pin("mute", 1'b1);
    wr(8'h07, 8'h01);
    pin("serial_data_out", 1'b0);
    wr(8'h08, 8'h00);
    pin("mute", 1'b0);
  endtask
  // Slave sampling edge for both polarities, with the captured pins.
  // The source never moves frame or data on the sampling edge, so the
  // pins just after it still show what the block should have taken.
  task automatic t_slave(logic v);
    int n;
    inv <= v;
    wr(8'h09, v ? 8'h20 : 8'h00);
    src_run <= 1;
    for (int k = 0; k < 4; k++)
    begin
      n = 0;
      do @(negedge REF_CLK); while (SMP_STB !== 1'b1 && ++n < 100);
      chk("stb", 16'h1, {15'h0, SMP_STB});
      chk("edge", {14'h0, !v, v}, {14'h0, bck_h});
      chk("frame", {15'h0, FRM_I}, {15'h0, SMP_FRM});
      chk("din", {15'h0, DIN}, {15'h0, SMP_SD});
    end
    src_run <= 0;
  endtask
  // Master clocks from the dividers with half counts of two.
  task automatic t_master;
    {BCK_HALF, FRM_HALF, inv} <= {8'h02, 8'h02, 1'b0};
    {BCK_DIV_RUN, FRM_DIV_RUN, src_run} <= 3'b111;
    wr(8'h09, 8'h11);
    chk("moe", 16'h0, {14'h0, BCK_OE_N, FRM_OE_N});
    per(1'b0, 4);
    per(1'b1, 16);
    {BCK_DIV_RUN, FRM_DIV_RUN, src_run} <= 3'b000;
    wr(8'h09, 8'h00);
  endtask
  initial
  begin
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1;
    @(negedge REF_CLK);
    t_regs();
    t_wrap();
    t_filter();
    t_pins();
    t_slave(1'b0);
    t_slave(1'b1);
    t_master();
    stop_test();
  end
  // Watchdog well beyond the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    failures++;
    stop_test();
  end
endmodule
